// *** core/sffc_regs.svh ***
// sffc_regs.svh: object indices, field values, reset values and scaling shifts
// assumes: included by the feedforward/friction core and its package users
`ifndef SFFC_REGS_SVH
`define SFFC_REGS_SVH

// object indices seen on the object access port
`define SFFC_OBJ_SPEED_FF_OFFSET   16'h60b1
`define SFFC_OBJ_TORQUE_FF_OFFSET  16'h60b2
`define SFFC_OBJ_INTERP_SUBMODE    16'h60c0

// interpolation submode value that selects cubic interpolation
`define SFFC_SUBMODE_CUBIC         16'hffff

// reset values
`define SFFC_RST_OBJ32             32'h0000_0000
`define SFFC_RST_OBJ16             16'h0000
`define SFFC_RST_DATA              32'h0000_0000
`define SFFC_ZERO32                32'h0000_0000

// fixed-point shifts: gains, percentages and coefficients are in 1/256 units
`define SFFC_GAIN_SHIFT            8
`define SFFC_MF_SHIFT              8
`define SFFC_VISC_SHIFT            8

// saturation bounds for 34-bit sums
`define SFFC_SAT_MAX               34'sh0_7fff_ffff
`define SFFC_SAT_MIN               -34'sh0_8000_0000
`define SFFC_OUT_MAX               32'h7fff_ffff
`define SFFC_OUT_MIN               32'h8000_0000

`endif

// *** core/sffc_pkg.sv ***
// sffc_pkg: selector encodings of the feedforward/friction core
// assumes: imported whole by the core module
package sffc_pkg;

  typedef enum logic [1:0] {
    SFFC_SRC_INT   = 2'h0,
    SFFC_SRC_MF    = 2'h1,
    SFFC_SRC_CTRL  = 2'h2,
    SFFC_SRC_CUBIC = 2'h3
  } sffc_src_t;

  typedef enum logic [1:0] {
    SFFC_ALGO_GEN  = 2'h0,
    SFFC_ALGO_HS   = 2'h2
  } sffc_algo_t;

  typedef enum logic [1:0] {
    SFFC_MF_OFF    = 2'h0,
    SFFC_MF_ON     = 2'h1,
    SFFC_MF_OSC    = 2'h2
  } sffc_mf_t;

endpackage

// *** core/sffc_top.sv ***
// sffc_top: speed/torque feedforward selection and friction compensation
// assumes: clk is the control-cycle clock, ce marks active cycles, all inputs come from
// logic on clk; the master controller writes objects through the object port
//
// Behaviour
// - speed feedforward source 0 internal, 1 model following, 2 controller speed offset, 3 cubic term.
// - torque feedforward source 0 internal, 1 model following, 2 controller torque offset, 3 cubic term.
// - the model-following source gives feedforward only while model following enable is 1 or 2.
// - internal speed feedforward is the position reference derivative times the speed gain.
// - internal torque feedforward is speed reference derivative times inertia percent times torque gain.
// - each internal term passes its own low-pass filter with a configurable time constant.
// - torque algorithm selector picks the general algorithm at 0 and the high-speed one at 2.
// - controller and cubic feedforward apply only while the drive runs over the fieldbus.
// - the controller writes a signed 32-bit speed offset and a signed 16-bit torque offset.
// - cubic feedforward applies only while the interpolation submode object holds the cubic value.
// - Coulomb compensation has a configured magnitude and the sign of the motor speed.
// - inside the speed dead band the friction compensation output is zero.
// - viscous compensation is motor speed times a configurable coefficient.
// - model-following percentages act only while a selector holds the model-following code.
`timescale 1ns/1ps
`include "sffc_regs.svh"

module sffc_top
  import sffc_pkg::*;
#(
  parameter int GW = 16,
  parameter int FW = 4
) (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  // selectors, sampled while sys_rst is high
  input  wire logic [1:0]         speedFfSourceSel,
  input  wire logic [1:0]         torqueFfSourceSel,
  input  wire logic [1:0]         torqueFfAlgoSel,
  input  wire logic [1:0]         modelFollowEnable,
  // drive operated over the fieldbus
  input  wire logic               fieldbusMode,
  // tuning settings, effective every cycle
  input  wire logic [GW-1:0]      speedFfGain,
  input  wire logic [FW-1:0]      speedFfFilterTime,
  input  wire logic [GW-1:0]      torqueFfGain,
  input  wire logic [FW-1:0]      torqueFfFilterTime,
  input  wire logic [GW-1:0]      loadInertiaPct,
  input  wire logic [GW-1:0]      mfSpeedFfPct,
  input  wire logic [GW-1:0]      mfTorqueFfPct,
  input  wire logic [GW-1:0]      coulombCompLevel,
  input  wire logic [31:0]        coulombDeadBand,
  input  wire logic [GW-1:0]      viscousCompCoeff,
  // references and feedback
  input  wire logic signed [31:0] posRef,
  input  wire logic signed [31:0] speedRef,
  input  wire logic signed [31:0] torqueRef,
  input  wire logic signed [31:0] motorSpeed,
  // external feedforward generators
  input  wire logic signed [31:0] mfSpeedFf,
  input  wire logic signed [31:0] mfTorqueFf,
  input  wire logic signed [31:0] cubicSpeedFf,
  input  wire logic signed [31:0] cubicTorqueFf,
  // object access
  input  wire logic               objWrEn,
  input  wire logic [15:0]        objIndex,
  input  wire logic [31:0]        objWrData,
  output logic      [31:0]        objRdData,
  // results
  output logic signed [31:0]      speedRefOut,
  output logic signed [31:0]      torqueRefOut,
  output logic signed [31:0]      speedFf,
  output logic signed [31:0]      torqueFf,
  output logic signed [31:0]      frictionComp
);

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  function automatic logic signed [31:0] scale(input logic signed [31:0] x,
                                               input logic [GW-1:0] g,
                                               input int sh);
    logic signed [GW+32:0] p;
    p = x * $signed({1'b0, g});
    p = p >>> sh;
    return p[31:0];
  endfunction

  // saturate rather than wrap: a wrapped torque sum flips direction
  function automatic logic signed [31:0] sat(input logic signed [33:0] s);
    logic signed [31:0] r;
    r = s[31:0];
    if (s > `SFFC_SAT_MAX) begin
      r = `SFFC_OUT_MAX;
    end else if (s < `SFFC_SAT_MIN) begin
      r = `SFFC_OUT_MIN;
    end
    return r;
  endfunction

  function automatic logic signed [31:0] lpf(input logic signed [31:0] y,
                                             input logic signed [31:0] x,
                                             input logic [FW-1:0] t);
    logic signed [32:0] d;
    d = 33'(x) - 33'(y);
    d = d >>> t;
    return sat(34'(y) + 34'(d));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  sffc_src_t          spdSel_q,     spdSel_d;
  sffc_src_t          trqSel_q,     trqSel_d;
  logic [1:0]         algoSel_q,    algoSel_d;
  logic [1:0]         mfEn_q,       mfEn_d;
  logic signed [31:0] speedOfs_q,   speedOfs_d;
  logic signed [15:0] torqueOfs_q,  torqueOfs_d;
  logic [15:0]        submode_q,    submode_d;
  logic signed [31:0] posPrev_q,    posPrev_d;
  logic signed [31:0] spdPrev_q,    spdPrev_d;
  logic signed [31:0] spdPrev2_q,   spdPrev2_d;
  logic               primed_q,     primed_d;
  logic signed [31:0] spdFilt_q,    spdFilt_d;
  logic signed [31:0] trqFilt_q,    trqFilt_d;
  logic [31:0]        rd_q,         rd_d;
  logic signed [31:0] spdOut_q,     spdOut_d;
  logic signed [31:0] trqOut_q,     trqOut_d;
  logic signed [31:0] spdFf_q,      spdFf_d;
  logic signed [31:0] trqFf_q,      trqFf_d;
  logic signed [31:0] fric_q,       fric_d;

  // combinational terms
  logic signed [31:0] posDiff;
  logic signed [31:0] spdDiff;
  logic signed [31:0] spdIntRaw;
  logic signed [31:0] trqIntRaw;
  logic signed [31:0] speedFfSel;
  logic signed [31:0] torqueFfSel;
  logic signed [31:0] frictionSel;
  logic               mfOk;
  logic               cubicOk;
  logic [31:0]        absSpeed;
  logic               inBand;
  logic signed [31:0] coulomb;
  logic signed [31:0] viscous;

  ////////////////////////////////////////////////////////////////////////////
  // feedforward and friction terms

  always_comb begin
    // first active cycle only seeds the history, so no derivative spike
    posDiff = primed_q ? sat(34'(posRef) - 34'(posPrev_q)) : `SFFC_ZERO32;
    if (!primed_q) begin
      spdDiff = `SFFC_ZERO32;
    end else if (algoSel_q == SFFC_ALGO_HS) begin
      // central difference over two cycles: less noise at high speed
      spdDiff = 32'((34'(speedRef) - 34'(spdPrev2_q)) >>> 1);
    end else begin
      spdDiff = sat(34'(speedRef) - 34'(spdPrev_q));
    end
    spdIntRaw = scale(posDiff, speedFfGain, `SFFC_GAIN_SHIFT);
    trqIntRaw = scale(scale(spdDiff, loadInertiaPct, `SFFC_GAIN_SHIFT),
                      torqueFfGain, `SFFC_GAIN_SHIFT);
    mfOk    = (mfEn_q == SFFC_MF_ON) || (mfEn_q == SFFC_MF_OSC);
    cubicOk = fieldbusMode && (submode_q == `SFFC_SUBMODE_CUBIC);

    unique case (spdSel_q)
      SFFC_SRC_INT:   speedFfSel = spdFilt_q;
      SFFC_SRC_MF:    speedFfSel = mfOk ? scale(mfSpeedFf, mfSpeedFfPct, `SFFC_MF_SHIFT) : `SFFC_ZERO32;
      SFFC_SRC_CTRL:  speedFfSel = fieldbusMode ? speedOfs_q : `SFFC_ZERO32;
      SFFC_SRC_CUBIC: speedFfSel = cubicOk ? cubicSpeedFf : `SFFC_ZERO32;
    endcase
    unique case (trqSel_q)
      SFFC_SRC_INT:   torqueFfSel = trqFilt_q;
      SFFC_SRC_MF:    torqueFfSel = mfOk ? scale(mfTorqueFf, mfTorqueFfPct, `SFFC_MF_SHIFT) : `SFFC_ZERO32;
      SFFC_SRC_CTRL:  torqueFfSel = fieldbusMode ? 32'(torqueOfs_q) : `SFFC_ZERO32;
      SFFC_SRC_CUBIC: torqueFfSel = cubicOk ? cubicTorqueFf : `SFFC_ZERO32;
    endcase

    absSpeed = motorSpeed[31] ? 32'(-motorSpeed) : motorSpeed;
    inBand   = absSpeed <= coulombDeadBand;
    coulomb  = motorSpeed[31] ? -32'($signed({1'b0, coulombCompLevel}))
                              : 32'($signed({1'b0, coulombCompLevel}));
    viscous  = scale(motorSpeed, viscousCompCoeff, `SFFC_VISC_SHIFT);
    // the whole compensation is held at zero in the band, so it cannot chatter
    frictionSel = inBand ? `SFFC_ZERO32 : sat(34'(coulomb) + 34'(viscous));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    spdSel_d    = spdSel_q;
    trqSel_d    = trqSel_q;
    algoSel_d   = algoSel_q;
    mfEn_d      = mfEn_q;
    speedOfs_d  = speedOfs_q;
    torqueOfs_d = torqueOfs_q;
    submode_d   = submode_q;
    posPrev_d   = posPrev_q;
    spdPrev_d   = spdPrev_q;
    spdPrev2_d  = spdPrev2_q;
    primed_d    = primed_q;
    spdFilt_d   = spdFilt_q;
    trqFilt_d   = trqFilt_q;
    rd_d        = rd_q;
    spdOut_d    = spdOut_q;
    trqOut_d    = trqOut_q;
    spdFf_d     = spdFf_q;
    trqFf_d     = trqFf_q;
    fric_d      = fric_q;
    if (sys_rst) begin
      // selectors are only taken here, so a change needs a restart
      spdSel_d    = sffc_src_t'(speedFfSourceSel);
      trqSel_d    = sffc_src_t'(torqueFfSourceSel);
      algoSel_d   = torqueFfAlgoSel;
      mfEn_d      = modelFollowEnable;
      speedOfs_d  = `SFFC_RST_OBJ32;
      torqueOfs_d = `SFFC_RST_OBJ16;
      submode_d   = `SFFC_RST_OBJ16;
      posPrev_d   = `SFFC_RST_DATA;
      spdPrev_d   = `SFFC_RST_DATA;
      spdPrev2_d  = `SFFC_RST_DATA;
      primed_d    = 1'b0;
      spdFilt_d   = `SFFC_RST_DATA;
      trqFilt_d   = `SFFC_RST_DATA;
      rd_d        = `SFFC_RST_DATA;
      spdOut_d    = `SFFC_RST_DATA;
      trqOut_d    = `SFFC_RST_DATA;
      spdFf_d     = `SFFC_RST_DATA;
      trqFf_d     = `SFFC_RST_DATA;
      fric_d      = `SFFC_RST_DATA;
    end else if (ce) begin
      if (objWrEn) begin
        unique case (objIndex)
          `SFFC_OBJ_SPEED_FF_OFFSET:  speedOfs_d  = objWrData;
          `SFFC_OBJ_TORQUE_FF_OFFSET: torqueOfs_d = objWrData[15:0];
          `SFFC_OBJ_INTERP_SUBMODE:   submode_d   = objWrData[15:0];
          default:                    ;
        endcase
      end
      unique case (objIndex)
        `SFFC_OBJ_SPEED_FF_OFFSET:  rd_d = speedOfs_q;
        `SFFC_OBJ_TORQUE_FF_OFFSET: rd_d = {16'h0000, torqueOfs_q};
        `SFFC_OBJ_INTERP_SUBMODE:   rd_d = {16'h0000, submode_q};
        default:                    rd_d = `SFFC_ZERO32;
      endcase
      posPrev_d  = posRef;
      spdPrev_d  = speedRef;
      // seed both taps on the first cycle, so the two-cycle difference starts without a spike
      spdPrev2_d = primed_q ? spdPrev_q : speedRef;
      primed_d   = 1'b1;
      spdFilt_d  = lpf(spdFilt_q, spdIntRaw, speedFfFilterTime);
      trqFilt_d  = lpf(trqFilt_q, trqIntRaw, torqueFfFilterTime);
      spdFf_d    = speedFfSel;
      trqFf_d    = torqueFfSel;
      fric_d     = frictionSel;
      spdOut_d   = sat(34'(speedRef) + 34'(speedFfSel));
      trqOut_d   = sat(34'(torqueRef) + 34'(torqueFfSel) + 34'(frictionSel));
    end
  end

  always_ff @(posedge clk) begin
    spdSel_q    <= spdSel_d;
    trqSel_q    <= trqSel_d;
    algoSel_q   <= algoSel_d;
    mfEn_q      <= mfEn_d;
    speedOfs_q  <= speedOfs_d;
    torqueOfs_q <= torqueOfs_d;
    submode_q   <= submode_d;
    posPrev_q   <= posPrev_d;
    spdPrev_q   <= spdPrev_d;
    spdPrev2_q  <= spdPrev2_d;
    primed_q    <= primed_d;
    spdFilt_q   <= spdFilt_d;
    trqFilt_q   <= trqFilt_d;
    rd_q        <= rd_d;
    spdOut_q    <= spdOut_d;
    trqOut_q    <= trqOut_d;
    spdFf_q     <= spdFf_d;
    trqFf_q     <= trqFf_d;
    fric_q      <= fric_d;
  end

  assign objRdData    = rd_q;
  assign speedRefOut  = spdOut_q;
  assign torqueRefOut = trqOut_q;
  assign speedFf      = spdFf_q;
  assign torqueFf     = trqFf_q;
  assign frictionComp = fric_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SPD_SUM: assert property (ce |=> speedRefOut == sat(34'($past(speedRef)) + 34'($past(speedFfSel))))
    else $error("speed reference sum wrong");
  AST_TRQ_SUM: assert property (ce |=> frictionComp == $past(frictionSel) && torqueRefOut ==
                                sat(34'($past(torqueRef)) + 34'($past(torqueFfSel)) + 34'($past(frictionSel))))
    else $error("torque reference sum wrong");
  AST_MF_GATE: assert property (ce && spdSel_q == SFFC_SRC_MF && !mfOk |=> speedFf == 0)
    else $error("model-following feedforward used while disabled");
  AST_BUS_GATE: assert property (trqSel_q == SFFC_SRC_CTRL && !fieldbusMode |-> torqueFfSel == 0)
    else $error("controller torque offset used off the fieldbus");
  AST_OFS_PATH: assert property (ce && spdSel_q == SFFC_SRC_CTRL && fieldbusMode
                                 |=> speedFf == $past(speedOfs_q))
    else $error("speed offset not selected");
  AST_OBJ_WR: assert property (ce && objWrEn && objIndex == `SFFC_OBJ_TORQUE_FF_OFFSET
                               |=> torqueOfs_q == $past(objWrData[15:0]))
    else $error("torque offset write lost");
  AST_CUBIC: assert property (spdSel_q == SFFC_SRC_CUBIC && submode_q != `SFFC_SUBMODE_CUBIC |-> speedFfSel == 0)
    else $error("cubic feedforward without cubic submode");
  AST_DEADBAND: assert property (ce && inBand |=> frictionComp == 0)
    else $error("friction nonzero in dead band");
  AST_COULOMB: assert property (ce && !inBand && viscousCompCoeff == 0 && motorSpeed > 0
                                |=> frictionComp == 32'($past(coulombCompLevel)))
    else $error("coulomb sign or level wrong");
  AST_SEL_HOLD: assert property (1'b1 |=> ($stable(spdSel_q) && $stable(trqSel_q)) [*2])
    else $error("selector changed outside reset");
  AST_FILT0: assert property (ce && speedFfFilterTime == 0 |=> spdFilt_q == $past(spdIntRaw))
    else $error("unfiltered internal speed term wrong");

  COV_INT: cover property (ce && spdSel_q == SFFC_SRC_INT && spdIntRaw != 0);
  COV_CTRL: cover property (ce && trqSel_q == SFFC_SRC_CTRL && fieldbusMode && torqueOfs_q != 0);
  COV_FRIC: cover property (ce && !inBand ##1 ce && inBand);

endmodule

// *** bench/sffc_master_model.sv ***
// sffc_master_model: cyclic fieldbus master that writes and reads drive objects
// assumes: shares clk with the drive; requests change only on the falling edge
`timescale 1ns/1ps

module sffc_master_model (
  // clock
  input  wire logic        clk,
  // object port towards the drive
  output logic             objWrEn,
  output logic [15:0]      objIndex,
  output logic [31:0]      objWrData,
  input  wire logic [31:0] objRdData
);
  initial begin
    objWrEn   = 1'b0;
    objIndex  = 16'h0000;
    objWrData = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one write a call; data is inverted after release so stale data never looks fresh
  task automatic write_obj(input logic [15:0] idx, input logic [31:0] dat);
    @(negedge clk);
    objWrEn   = 1'b1;
    objIndex  = idx;
    objWrData = dat;
    @(negedge clk);
    objWrEn   = 1'b0;
    objWrData = ~dat;
  endtask

  task automatic read_obj(input logic [15:0] idx, output logic [31:0] dat);
    @(negedge clk);
    objIndex = idx;
    repeat (2) @(negedge clk);
    dat = objRdData;
  endtask
endmodule

// *** bench/tb_sffc_top.sv ***
// tb_sffc_top: self-checking bench of the feedforward and friction core
// assumes: the master model owns the object port; other inputs change on the falling edge
`timescale 1ns/1ps
`include "sffc_regs.svh"

module tb_sffc_top;
  typedef struct {
    logic [1:0] sp, tq, algo, mf;
    logic fb;
    logic [15:0] sub;
    logic signed [31:0] ms, eS, eT, eF;
  } sffc_row_t;

  logic clk, sysRst, ce, fb;
  logic [1:0] spSel, tqSel, algoSel, mfEn;
  logic [15:0] spGain, tqGain, inertia, mfSpPct, mfTqPct, coulLvl, viscCoeff;
  logic [3:0] spFilt, tqFilt;
  logic [31:0] deadBand, objRdData, rd;
  logic signed [31:0] posRef, speedRef, torqueRef, motorSpeed, step;
  logic objWrEn;
  logic [15:0] objIndex;
  logic [31:0] objWrData;
  logic signed [31:0] speedRefOut, torqueRefOut, speedFf, torqueFf, frictionComp;
  int error_cnt, tests_run, cyc;
  sffc_row_t rows[9];
  logic signed [31:0] msv[5], cv[5], ef[5];

  sffc_top uut (.clk(clk), .sys_rst(sysRst), .ce(ce), .speedFfSourceSel(spSel), .torqueFfSourceSel(tqSel),
    .torqueFfAlgoSel(algoSel), .modelFollowEnable(mfEn), .fieldbusMode(fb), .speedFfGain(spGain),
    .speedFfFilterTime(spFilt), .torqueFfGain(tqGain), .torqueFfFilterTime(tqFilt), .loadInertiaPct(inertia),
    .mfSpeedFfPct(mfSpPct), .mfTorqueFfPct(mfTqPct), .coulombCompLevel(coulLvl), .coulombDeadBand(deadBand),
    .viscousCompCoeff(viscCoeff), .posRef(posRef), .speedRef(speedRef), .torqueRef(torqueRef),
    .motorSpeed(motorSpeed), .mfSpeedFf(32'sd3000), .mfTorqueFf(32'sd600), .cubicSpeedFf(32'sd7000),
    .cubicTorqueFf(32'sd70), .objWrEn(objWrEn), .objIndex(objIndex), .objWrData(objWrData),
    .objRdData(objRdData), .speedRefOut(speedRefOut), .torqueRefOut(torqueRefOut), .speedFf(speedFf),
    .torqueFf(torqueFf), .frictionComp(frictionComp));

  sffc_master_model master (.clk(clk), .objWrEn(objWrEn), .objIndex(objIndex), .objWrData(objWrData),
    .objRdData(objRdData));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ramps keep both derivatives constant once history has settled
  always @(negedge clk) begin
    posRef   <= posRef + step;
    speedRef <= speedRef + 32'sd4;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 1500) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {ce, fb, spSel, tqSel, algoSel, mfEn} = '0;
    sysRst = 1'b1;
    {spFilt, tqFilt, cyc, error_cnt, tests_run} = '0;
    {spGain, tqGain, inertia, mfSpPct, mfTqPct} = {16'h0100, 16'h0200, 16'h0100, 16'h0080, 16'h0100};
    {coulLvl, viscCoeff, deadBand} = {16'h0032, 16'h0200, 32'h0000_000a};
    {posRef, speedRef, torqueRef, motorSpeed, step} = {32'sd0, 32'sd1000, 32'sd10000, 32'sd0, 32'sd100};
    rows = '{'{0, 0, 0, 0, 1, 0, 20, 100, 8, 90}, '{1, 1, 0, 1, 1, 0, -20, 1500, 600, -90},
             '{1, 1, 0, 2, 1, 0, 5, 1500, 600, 0}, '{1, 1, 0, 0, 1, 0, 5, 0, 0, 0},
             '{2, 2, 0, 0, 1, 0, 5, -5000, -200, 0}, '{2, 2, 0, 0, 0, 0, 5, 0, 0, 0},
             '{3, 3, 0, 0, 1, 16'hffff, 5, 7000, 70, 0}, '{3, 3, 0, 0, 1, 16'h0001, 5, 0, 0, 0},
             '{0, 0, 2, 0, 1, 0, 5, 100, 8, 0}};
    ce = 1'b1;
    foreach (rows[i]) begin
      @(negedge clk);
      {spSel, tqSel, algoSel, mfEn} = {rows[i].sp, rows[i].tq, rows[i].algo, rows[i].mf};
      sysRst = 1'b1;
      repeat (i == 0 ? 15 : 2) @(negedge clk);
      chk("reset speedRefOut", speedRefOut, 32'h0000_0000);
      chk("reset friction", frictionComp, 32'h0000_0000);
      sysRst = 1'b0;
      {fb, motorSpeed} = {rows[i].fb, rows[i].ms};
      master.write_obj(`SFFC_OBJ_SPEED_FF_OFFSET, 32'hffff_ec78);
      master.write_obj(`SFFC_OBJ_TORQUE_FF_OFFSET, 32'h0000_ff38);
      master.write_obj(`SFFC_OBJ_INTERP_SUBMODE, {16'h0000, rows[i].sub});
      repeat (10) @(negedge clk);
      chk("speedFf", speedFf, rows[i].eS);
      chk("torqueFf", torqueFf, rows[i].eT);
      chk("frictionComp", frictionComp, rows[i].eF);
      chk("speedRefOut", speedRefOut, speedRef + rows[i].eS);
      chk("torqueRefOut", torqueRefOut, torqueRef + rows[i].eT + rows[i].eF);
    end
    // selector held without reset, gain acts at once
    {spSel, spGain} = {2'h2, 16'h0200};
    repeat (6) @(negedge clk);
    chk("held select gain", speedFf, 32'sd200);
    // a shift-1 filter creeping up to a step of 300 stalls one count short
    {spGain, step, spFilt} = {16'h0100, 32'sd300, 4'h1};
    repeat (30) @(negedge clk);
    chk("filtered speedFf", speedFf, 32'sd299);
    // dead band edge is inside the band; viscous coefficient changes live
    msv = '{10, 11, -11, 11, 11};
    cv  = '{512, 512, 512, 256, 0};
    ef  = '{0, 72, -72, 61, 50};
    foreach (msv[i]) begin
      {motorSpeed, viscCoeff} = {msv[i], cv[i][15:0]};
      repeat (2) @(negedge clk);
      chk("band friction", frictionComp, ef[i]);
    end
    // enable low freezes the outputs although the references keep ramping
    rd = speedRefOut;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    chk("frozen speedRefOut", speedRefOut, rd);
    ce = 1'b1;
    master.read_obj(`SFFC_OBJ_SPEED_FF_OFFSET, rd);
    chk("speed offset rd", rd, 32'hffff_ec78);
    master.write_obj(`SFFC_OBJ_TORQUE_FF_OFFSET, 32'h1234_ff38);
    master.read_obj(`SFFC_OBJ_TORQUE_FF_OFFSET, rd);
    chk("torque offset rd", rd, 32'h0000_ff38);
    master.read_obj(16'h6000, rd);
    chk("unmapped rd", rd, 32'h0000_0000);
    wrap_up();
  end
endmodule
